// *** rtl/vgcr_map.svh ***
// Offsets, field positions, reset values and timing figures of the gain-control registers
`ifndef VGCR_MAP_SVH
`define VGCR_MAP_SVH

// Register indices; byte address is four times the index
`define VGCR_IDX_MODE 6'h2c
`define VGCR_IDX_CHI 6'h2d
`define VGCR_IDX_CLO 6'h2e
`define VGCR_IDX_LHI 6'h2f
`define VGCR_IDX_LLO 6'h30
`define VGCR_IDX_SHI 6'h31

// Field positions
`define VGCR_CMODE_LSB 0
`define VGCR_LMODE_LSB 4
`define VGCR_TIME_LSB 6
`define VGCR_SHADOW_EN_BIT 7

// Reserved bits that read as one
`define VGCR_RSV_MODE 8'h8c
`define VGCR_RSV_GAIN 8'h30
`define VGCR_RSV_SHADOW 8'h70

// Reset values
`define VGCR_RST_MODE 8'hae
`define VGCR_RST_CHI 8'hf0
`define VGCR_RST_CLO 8'h00
`define VGCR_RST_LHI 8'hf0
`define VGCR_RST_LLO 8'h00
`define VGCR_RST_SHI 8'h70

// Tracking time constants in ms, clock in kHz
`define VGCR_TC_SLOW_MS 2000
`define VGCR_TC_MED_MS 1000
`define VGCR_TC_FAST_MS 200
`define VGCR_CLK_KHZ 50000
`define VGCR_TRACK_STEPS 256

`endif

// *** rtl/vgcr_pkg.sv ***
// Types of the gain-control register set
package vgcr_pkg;

    typedef enum logic [1:0] {
        VGCR_C_MANUAL = 2'h0,
        VGCR_C_LUMA = 2'h1,
        VGCR_C_BURST = 2'h2,
        VGCR_C_FREEZE = 2'h3
    } vgcr_cmode_e;

    typedef enum logic [2:0] {
        VGCR_L_MANUAL = 3'h0,
        VGCR_L_SYNC_A = 3'h1,
        VGCR_L_OVR_A = 3'h2,
        VGCR_L_SYNC_B = 3'h3,
        VGCR_L_OVR_B = 3'h4,
        VGCR_L_PEAK = 3'h5,
        VGCR_L_AVG = 3'h6,
        VGCR_L_FREEZE = 3'h7
    } vgcr_lmode_e;

    typedef enum logic [1:0] {
        VGCR_T_SLOW = 2'h0,
        VGCR_T_MED = 2'h1,
        VGCR_T_FAST = 2'h2,
        VGCR_T_QUAL = 2'h3
    } vgcr_time_e;

endpackage

// *** rtl/vgcr_regs.sv ***
// Gain-control register set with APB slave and gain selection
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`include "vgcr_map.svh"
// Overview of operation
// - Chroma mode picks manual, luma, burst, freeze
// - Chroma timing applies only in burst mode
// - Luma timing picks slow, medium, fast, quality
// - Luma mode 000 uses manual luma gain
// - Modes 001/011 sync-measured, no peak override
// - Modes 010/100 sync-measured with peak override
// - 101 peak, 110 average, 111 freeze
// - Manual chroma gain split over two registers
// - Chroma gain reads back gain in use
// - Luma gain written manual, reads gain used
// - Shadow enable bit and shadow high nibble
// - Shadow enable turns on surveillance mode in luma manual mode
// - Shadow gain active only in manual mode
module vgcr_regs #(
    parameter int unsigned GAIN_W = 12,
    parameter int unsigned CNT_W = 20,
    parameter int unsigned SLOW_CYC = `VGCR_TC_SLOW_MS * `VGCR_CLK_KHZ / `VGCR_TRACK_STEPS,
    parameter int unsigned MED_CYC = `VGCR_TC_MED_MS * `VGCR_CLK_KHZ / `VGCR_TRACK_STEPS,
    parameter int unsigned FAST_CYC = `VGCR_TC_FAST_MS * `VGCR_CLK_KHZ / `VGCR_TRACK_STEPS
) (
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Gain loop side
    input wire logic [GAIN_W-1:0] chroma_loop_gain_in,
    input wire logic [GAIN_W-1:0] luma_loop_gain_in,
    input wire logic [7:0] shadow_gain_low_in,
    input wire logic video_quality_in,
    output logic [GAIN_W-1:0] chroma_gain_out,
    output logic [GAIN_W-1:0] luma_gain_out,
    output logic chroma_track_en_out,
    output logic luma_track_en_out,
    output logic chroma_step_out,
    output logic luma_step_out,
    output logic luma_sync_measure_out,
    output logic luma_peak_override_out,
    output logic luma_peak_measure_out,
    output logic luma_avg_measure_out,
    output logic surveillance_out
);

    vgcr_pkg::vgcr_cmode_e chroma_gain_mode;
    vgcr_pkg::vgcr_lmode_e luma_gain_mode;
    logic [1:0] chroma_gain_timing;
    logic [1:0] luma_gain_timing;
    logic [GAIN_W-1:0] manual_chroma_gain;
    logic [GAIN_W-1:0] manual_luma_gain;
    logic [3:0] shadow_luma_gain;
    logic shadow_update_enable;
    logic [GAIN_W-1:0] chroma_gain;
    logic [GAIN_W-1:0] luma_gain;
    logic [5:0] idx;
    logic hit;
    logic wr_en;
    logic rd_setup;
    logic [7:0] next_rdata;
    logic luma_manual;
    logic [1:0] trk_en;
    logic [3:0] trk_sel;
    logic [1:0] step;

    // APB decode
    assign idx = paddr_in[7:2];
    assign hit = (paddr_in[1:0] == 2'h0) && (idx >= `VGCR_IDX_MODE) && (idx <= `VGCR_IDX_SHI);
    assign wr_en = ce_in && psel_in && penable_in && pwrite_in && hit && pstrb_in[0];
    assign rd_setup = ce_in && psel_in && !penable_in && !pwrite_in;
    assign pready_out = ce_in;
    assign pslverr_out = psel_in && penable_in && !hit;
    assign luma_manual = (luma_gain_mode == vgcr_pkg::VGCR_L_MANUAL);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            chroma_gain_mode <= vgcr_pkg::vgcr_cmode_e'(`VGCR_RST_MODE & 8'h03);
            luma_gain_mode <= vgcr_pkg::vgcr_lmode_e'((`VGCR_RST_MODE >> `VGCR_LMODE_LSB) & 8'h07);
        end else if (wr_en && idx == `VGCR_IDX_MODE) begin
            chroma_gain_mode <= vgcr_pkg::vgcr_cmode_e'(pwdata_in[`VGCR_CMODE_LSB +: 2]);
            luma_gain_mode <= vgcr_pkg::vgcr_lmode_e'(pwdata_in[`VGCR_LMODE_LSB +: 3]);
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            manual_chroma_gain <= {4'(`VGCR_RST_CHI), 8'(`VGCR_RST_CLO)};
            chroma_gain_timing <= 2'(`VGCR_RST_CHI >> `VGCR_TIME_LSB);
        end else if (wr_en && idx == `VGCR_IDX_CHI) begin
            manual_chroma_gain[11:8] <= pwdata_in[3:0];
            chroma_gain_timing <= pwdata_in[`VGCR_TIME_LSB +: 2];
        end else if (wr_en && idx == `VGCR_IDX_CLO) begin
            manual_chroma_gain[7:0] <= pwdata_in[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            manual_luma_gain <= {4'(`VGCR_RST_LHI), 8'(`VGCR_RST_LLO)};
            luma_gain_timing <= 2'(`VGCR_RST_LHI >> `VGCR_TIME_LSB);
        end else if (wr_en && idx == `VGCR_IDX_LHI) begin
            manual_luma_gain[11:8] <= pwdata_in[3:0];
            luma_gain_timing <= pwdata_in[`VGCR_TIME_LSB +: 2];
        end else if (wr_en && idx == `VGCR_IDX_LLO) begin
            manual_luma_gain[7:0] <= pwdata_in[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            shadow_update_enable <= 1'b0;
            shadow_luma_gain <= 4'(`VGCR_RST_SHI);
        end else if (wr_en && idx == `VGCR_IDX_SHI) begin
            shadow_update_enable <= pwdata_in[`VGCR_SHADOW_EN_BIT];
            shadow_luma_gain <= pwdata_in[3:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            chroma_gain <= '0;
        end else if (ce_in) begin
            unique case (chroma_gain_mode)
                vgcr_pkg::VGCR_C_MANUAL: chroma_gain <= manual_chroma_gain;
                vgcr_pkg::VGCR_C_LUMA: chroma_gain <= luma_gain;
                vgcr_pkg::VGCR_C_BURST: chroma_gain <= chroma_loop_gain_in;
                vgcr_pkg::VGCR_C_FREEZE: chroma_gain <= chroma_gain;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            luma_gain <= '0;
        end else if (ce_in) begin
            unique case (luma_gain_mode)
                vgcr_pkg::VGCR_L_MANUAL: begin
                    luma_gain <= shadow_update_enable ? {shadow_luma_gain, shadow_gain_low_in} : manual_luma_gain;
                end
                vgcr_pkg::VGCR_L_FREEZE: luma_gain <= luma_gain;
                vgcr_pkg::VGCR_L_SYNC_A, vgcr_pkg::VGCR_L_SYNC_B, vgcr_pkg::VGCR_L_OVR_A,
                vgcr_pkg::VGCR_L_OVR_B, vgcr_pkg::VGCR_L_PEAK, vgcr_pkg::VGCR_L_AVG: begin
                    luma_gain <= luma_loop_gain_in;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            luma_sync_measure_out <= 1'b0;
            luma_peak_override_out <= 1'b0;
            luma_peak_measure_out <= 1'b0;
            luma_avg_measure_out <= 1'b0;
            surveillance_out <= 1'b0;
        end else if (ce_in) begin
            luma_sync_measure_out <= (luma_gain_mode inside {vgcr_pkg::VGCR_L_SYNC_A, vgcr_pkg::VGCR_L_SYNC_B,
                vgcr_pkg::VGCR_L_OVR_A, vgcr_pkg::VGCR_L_OVR_B});
            luma_peak_override_out <= (luma_gain_mode inside {vgcr_pkg::VGCR_L_OVR_A, vgcr_pkg::VGCR_L_OVR_B});
            luma_peak_measure_out <= (luma_gain_mode == vgcr_pkg::VGCR_L_PEAK);
            luma_avg_measure_out <= (luma_gain_mode == vgcr_pkg::VGCR_L_AVG);
            surveillance_out <= shadow_update_enable && luma_manual;
        end
    end

    assign trk_en[0] = (chroma_gain_mode == vgcr_pkg::VGCR_C_BURST);
    assign trk_en[1] = !luma_manual && (luma_gain_mode != vgcr_pkg::VGCR_L_FREEZE);
    assign trk_sel = {luma_gain_timing, chroma_gain_timing};
    assign chroma_track_en_out = trk_en[0];
    assign luma_track_en_out = trk_en[1];
    assign chroma_step_out = step[0];
    assign luma_step_out = step[1];

    genvar g;
    for (g = 0; g < 2; g++) begin : g_trk
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] period;
        logic step_q;
        always_comb begin
            unique case (vgcr_pkg::vgcr_time_e'(trk_sel[g*2 +: 2]))
                vgcr_pkg::VGCR_T_SLOW: period = CNT_W'(SLOW_CYC);
                vgcr_pkg::VGCR_T_MED: period = CNT_W'(MED_CYC);
                vgcr_pkg::VGCR_T_FAST: period = CNT_W'(FAST_CYC);
                // Stable video tracks slowly
                vgcr_pkg::VGCR_T_QUAL: period = video_quality_in ? CNT_W'(SLOW_CYC) : CNT_W'(FAST_CYC);
            endcase
        end
        always_ff @(posedge clk_in) begin
            if (reset_in) begin
                cnt <= '0;
                step_q <= 1'b0;
            end else if (ce_in) begin
                if (!trk_en[g]) begin
                    cnt <= '0;
                    step_q <= 1'b0;
                end else if (cnt >= period - CNT_W'(1)) begin
                    cnt <= '0;
                    step_q <= 1'b1;
                end else begin
                    cnt <= cnt + CNT_W'(1);
                    step_q <= 1'b0;
                end
            end
        end
        assign step[g] = step_q;
    end

    assign chroma_gain_out = chroma_gain;
    assign luma_gain_out = luma_gain;

    always_comb begin
        next_rdata = 8'h00;
        unique case (idx)
            `VGCR_IDX_MODE: begin
                next_rdata = `VGCR_RSV_MODE | {1'b0, luma_gain_mode, 2'b00, chroma_gain_mode};
            end
            `VGCR_IDX_CHI: next_rdata = `VGCR_RSV_GAIN | {chroma_gain_timing, 2'b00, chroma_gain[11:8]};
            `VGCR_IDX_CLO: next_rdata = chroma_gain[7:0];
            `VGCR_IDX_LHI: next_rdata = `VGCR_RSV_GAIN | {luma_gain_timing, 2'b00, luma_gain[11:8]};
            `VGCR_IDX_LLO: next_rdata = luma_gain[7:0];
            `VGCR_IDX_SHI: begin
                next_rdata = `VGCR_RSV_SHADOW | {shadow_update_enable, 3'b000,
                    (surveillance_out ? luma_gain[11:8] : shadow_luma_gain)};
            end
            default: next_rdata = 8'h00;
        endcase
        if (!hit) begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            prdata_out <= '0;
        end else if (rd_setup) begin
            prdata_out <= {24'h000000, next_rdata};
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    chk_chroma_manual_gain: assert property (
        ce_in && chroma_gain_mode == vgcr_pkg::VGCR_C_MANUAL |=> chroma_gain_out == $past(manual_chroma_gain))
        else $error("chroma gain not manual value");
    chk_chroma_freeze_hold: assert property (
        ce_in && chroma_gain_mode == vgcr_pkg::VGCR_C_FREEZE |=> $stable(chroma_gain_out))
        else $error("chroma gain moved while frozen");
    chk_chroma_step_gate: assert property (
        chroma_gain_mode != vgcr_pkg::VGCR_C_BURST |=> !chroma_step_out || !$past(ce_in))
        else $error("chroma step outside burst mode");
    chk_luma_fast_step: assert property (
        luma_step_out && ce_in && trk_en[1] && luma_gain_timing == 2'h2 && $stable(luma_gain_timing)
        |=> !luma_step_out)
        else $error("luma step too long");
    chk_luma_manual_gain: assert property (
        ce_in && luma_manual && !shadow_update_enable |=> luma_gain_out == $past(manual_luma_gain))
        else $error("luma gain not manual value");
    chk_sync_no_override: assert property (
        ce_in && luma_gain_mode inside {vgcr_pkg::VGCR_L_SYNC_A, vgcr_pkg::VGCR_L_SYNC_B}
        |=> luma_sync_measure_out && !luma_peak_override_out)
        else $error("sync mode controls wrong");
    chk_sync_override: assert property (
        ce_in && luma_gain_mode inside {vgcr_pkg::VGCR_L_OVR_A, vgcr_pkg::VGCR_L_OVR_B}
        |=> luma_sync_measure_out && luma_peak_override_out)
        else $error("override mode controls wrong");
    chk_active_video: assert property (
        ce_in && luma_gain_mode == vgcr_pkg::VGCR_L_AVG |=> luma_avg_measure_out && !luma_peak_measure_out)
        else $error("average mode controls wrong");
    chk_chroma_high_write: assert property (
        wr_en && idx == `VGCR_IDX_CHI |=> manual_chroma_gain[11:8] == $past(pwdata_in[3:0]))
        else $error("chroma high nibble not stored");
    chk_chroma_readback: assert property (
        rd_setup && paddr_in == {`VGCR_IDX_CLO, 2'b00} |=> prdata_out == {24'h000000, $past(chroma_gain[7:0])})
        else $error("chroma readback wrong");
    chk_luma_readback: assert property (
        rd_setup && paddr_in == {`VGCR_IDX_LLO, 2'b00} |=> prdata_out == {24'h000000, $past(luma_gain[7:0])})
        else $error("luma readback wrong");
    chk_shadow_enable_bit: assert property (
        wr_en && idx == `VGCR_IDX_SHI |=> shadow_update_enable == $past(pwdata_in[7]))
        else $error("shadow enable not stored");
    chk_shadow_only_manual: assert property (
        ce_in && !luma_manual |=> !surveillance_out)
        else $error("surveillance outside manual mode");
    chk_chroma_follow_luma: assert property (
        ce_in && chroma_gain_mode == vgcr_pkg::VGCR_C_LUMA |=> chroma_gain_out == $past(luma_gain))
        else $error("chroma gain not following luma gain");
    chk_chroma_burst_gain: assert property (
        ce_in && chroma_gain_mode == vgcr_pkg::VGCR_C_BURST |=> chroma_gain_out == $past(chroma_loop_gain_in))
        else $error("chroma gain not loop value");
    chk_gain_ce_hold: assert property (
        !ce_in |=> $stable(chroma_gain_out) && $stable(luma_gain_out))
        else $error("gain moved while clock enable low");
    chk_chroma_timing_store: assert property (
        wr_en && idx == `VGCR_IDX_CHI |=> chroma_gain_timing == $past(pwdata_in[7:6]))
        else $error("chroma timing not stored");
    chk_chroma_fast_step: assert property (
        chroma_step_out && ce_in && trk_en[0] && chroma_gain_timing == 2'h2 && $stable(chroma_gain_timing)
        |=> !chroma_step_out)
        else $error("chroma step too long");
    chk_luma_timing_store: assert property (
        wr_en && idx == `VGCR_IDX_LHI |=> luma_gain_timing == $past(pwdata_in[7:6]))
        else $error("luma timing not stored");
    chk_luma_loop_gain: assert property (
        ce_in && luma_track_en_out |=> luma_gain_out == $past(luma_loop_gain_in))
        else $error("luma gain not loop value");
    chk_peak_mode: assert property (
        ce_in && luma_gain_mode == vgcr_pkg::VGCR_L_PEAK
        |=> luma_peak_measure_out && !luma_avg_measure_out && !luma_sync_measure_out)
        else $error("peak mode controls wrong");
    chk_luma_freeze_hold: assert property (
        ce_in && luma_gain_mode == vgcr_pkg::VGCR_L_FREEZE |=> $stable(luma_gain_out))
        else $error("luma gain moved while frozen");
    chk_luma_high_write: assert property (
        wr_en && idx == `VGCR_IDX_LHI |=> manual_luma_gain[11:8] == $past(pwdata_in[3:0]))
        else $error("luma high nibble not stored");
    chk_surveillance_on: assert property (
        ce_in && luma_manual && shadow_update_enable |=> surveillance_out)
        else $error("surveillance not entered");
    chk_shadow_gain_use: assert property (
        ce_in && luma_manual && shadow_update_enable
        |=> luma_gain_out == {$past(shadow_luma_gain), $past(shadow_gain_low_in)})
        else $error("shadow gain not in use");

endmodule // vgcr_regs

// *** verification/video_gain_control_regs_tb.sv ***
// Self-checking bench of the gain-control register set
`timescale 1ns/1ns
`include "vgcr_map.svh"
module video_gain_control_regs_tb;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic ce_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [3:0] pstrb_in = 4'hf;
    logic [11:0] chroma_loop_gain_in = 12'h5a3;
    logic [11:0] luma_loop_gain_in = 12'h3c7;
    logic [7:0] shadow_gain_low_in = 8'h9e;
    logic video_quality_in = 1'b1;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic [11:0] chroma_gain_out;
    logic [11:0] luma_gain_out;
    logic chroma_track_en_out;
    logic luma_track_en_out;
    logic chroma_step_out;
    logic luma_step_out;
    logic luma_sync_measure_out;
    logic luma_peak_override_out;
    logic luma_peak_measure_out;
    logic luma_avg_measure_out;
    logic surveillance_out;
    int fail_count = 0;
    int total_checks = 0;
    int cnt;
    int cnt2;
    logic [31:0] rd;
    logic err;
    logic [11:0] cexp [4] = '{12'ha5c, 12'h123, 12'h5a3, 12'h5a3};
    logic [4:0] lflags [8] = '{5'h00, 5'h18, 5'h1c, 5'h18, 5'h1c, 5'h12, 5'h11, 5'h00};
    int per [5] = '{8, 4, 2, 8, 2};

    vgcr_regs #(.SLOW_CYC(8), .MED_CYC(4), .FAST_CYC(2)) u_dut (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .pstrb_in(pstrb_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .chroma_loop_gain_in(chroma_loop_gain_in),
        .luma_loop_gain_in(luma_loop_gain_in),
        .shadow_gain_low_in(shadow_gain_low_in),
        .video_quality_in(video_quality_in),
        .chroma_gain_out(chroma_gain_out),
        .luma_gain_out(luma_gain_out),
        .chroma_track_en_out(chroma_track_en_out),
        .luma_track_en_out(luma_track_en_out),
        .chroma_step_out(chroma_step_out),
        .luma_step_out(luma_step_out),
        .luma_sync_measure_out(luma_sync_measure_out),
        .luma_peak_override_out(luma_peak_override_out),
        .luma_peak_measure_out(luma_peak_measure_out),
        .luma_avg_measure_out(luma_avg_measure_out),
        .surveillance_out(surveillance_out)
    );

    always #10 clk_in = ~clk_in;

    task automatic conclude();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= {idx, 2'b00};
        pwdata_in <= {24'h0, d};
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1) @(posedge clk_in);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask

    task automatic settle();
        repeat (2) @(negedge clk_in);
    endtask

    // Counts step pulses of both paths over 48 cycles
    task automatic count_steps();
        cnt = 0;
        cnt2 = 0;
        repeat (48) begin
            @(negedge clk_in);
            if (chroma_step_out === 1'b1) cnt++;
            if (luma_step_out === 1'b1) cnt2++;
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        rdchk(`VGCR_IDX_MODE, 8'hae);
        rdchk(`VGCR_IDX_CHI, 8'hf5);
        rdchk(`VGCR_IDX_CLO, 8'ha3);
        rdchk(`VGCR_IDX_LHI, 8'hf3);
        rdchk(`VGCR_IDX_LLO, 8'hc7);
        rdchk(`VGCR_IDX_SHI, 8'h70);
        apb(1'b0, 6'h00, 8'h00);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        // Reserved bits written as ones
        apb(1'b1, `VGCR_IDX_LHI, 8'h31);
        apb(1'b1, `VGCR_IDX_LLO, 8'h23);
        apb(1'b1, `VGCR_IDX_CHI, 8'h3a);
        apb(1'b1, `VGCR_IDX_CLO, 8'h5c);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `VGCR_IDX_MODE, 8'h8c | {6'h0, m[1:0]});
            if (m == 3) chroma_loop_gain_in <= 12'h777;
            settle();
            chk({20'h0, chroma_gain_out}, {20'h0, cexp[m]});
            chk({31'h0, chroma_track_en_out}, {31'h0, m == 2});
            rdchk(`VGCR_IDX_CLO, cexp[m][7:0]);
        end
        apb(1'b1, `VGCR_IDX_MODE, 8'h8c);
        settle();
        rdchk(`VGCR_IDX_CHI, 8'h3a);
        pstrb_in <= 4'h0;
        apb(1'b1, `VGCR_IDX_CLO, 8'hff);
        pstrb_in <= 4'hf;
        settle();
        rdchk(`VGCR_IDX_CLO, 8'h5c);
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, `VGCR_IDX_MODE, 8'h8f | {1'b0, m[2:0], 4'h0});
            if (m == 7) luma_loop_gain_in <= 12'h444;
            settle();
            chk({20'h0, luma_gain_out}, (m == 0) ? 32'h123 : 32'h3c7);
            chk({27'h0, luma_track_en_out, luma_sync_measure_out, luma_peak_override_out,
                 luma_peak_measure_out, luma_avg_measure_out}, {27'h0, lflags[m]});
        end
        @(posedge clk_in);
        luma_loop_gain_in <= 12'h3c7;
        apb(1'b1, `VGCR_IDX_SHI, 8'hf5);
        apb(1'b1, `VGCR_IDX_MODE, 8'h8f);
        settle();
        chk({31'h0, surveillance_out}, 32'h1);
        chk({20'h0, luma_gain_out}, 32'h59e);
        rdchk(`VGCR_IDX_SHI, 8'hf5);
        apb(1'b1, `VGCR_IDX_MODE, 8'h9f);
        settle();
        chk({31'h0, surveillance_out}, 32'h0);
        chk({20'h0, luma_gain_out}, 32'h3c7);
        count_steps();
        chk(cnt, 0);
        chk({31'h0, cnt2 >= 5 && cnt2 <= 7}, 32'h1);
        apb(1'b1, `VGCR_IDX_MODE, 8'h9e);
        for (int t = 0; t < 5; t++) begin
            @(posedge clk_in);
            video_quality_in <= (t != 4);
            apb(1'b1, `VGCR_IDX_CHI, {(t == 4) ? 2'h3 : t[1:0], 6'h3a});
            apb(1'b1, `VGCR_IDX_LHI, {(t == 4) ? 2'h3 : t[1:0], 6'h31});
            count_steps();
            chk({31'h0, cnt >= 48 / per[t] - 1 && cnt <= 48 / per[t] + 1}, 32'h1);
            chk({31'h0, cnt2 >= 48 / per[t] - 1 && cnt2 <= 48 / per[t] + 1}, 32'h1);
        end
        // Clock enable low freezes the gains and the bus
        @(posedge clk_in);
        ce_in <= 1'b0;
        chroma_loop_gain_in <= 12'h2b1;
        luma_loop_gain_in <= 12'h1d4;
        settle();
        chk({31'h0, pready_out}, 32'h0);
        chk({20'h0, chroma_gain_out}, 32'h777);
        chk({20'h0, luma_gain_out}, 32'h3c7);
        @(posedge clk_in);
        ce_in <= 1'b1;
        settle();
        chk({20'h0, chroma_gain_out}, 32'h2b1);
        chk({20'h0, luma_gain_out}, 32'h1d4);
        conclude();
    end
endmodule // video_gain_control_regs_tb
